//--- rtl/sdfc_filter_ctrl.sv
// decimation filter control: config register, output timing, settling and ready
`timescale 1ns/1ns

// Overview of operation
// - any control write resets both converters
// - chop bit chops every active converter
// - chop with zero averaging triples period
// - bit 14 enables running average of two
// - chopping forces running average on
// - running average bit adds one settling period when not chopping
// - bits 13..8 set averaging postfilter factor
// - averaging multiplies period by three plus factor
// - bit 7 adds second sinc3 notch
// - bits 6..0 set sinc3 decimation period
// - decimation 126 gives 60 Hz, 127 50 Hz, at the normal modulator clock
// - chopped period adds three modulator clocks
// - settling periods depend on averaging mode
// - extra 60 us before first result
// - slowest rate 4 Hz, low power 1 Hz
// - low power uses 131 kHz modulator clock
module sdfc_filter_ctrl #(
  parameter int WAKE_CNT = sdfc_pkg::WAKE_CYCLES,
  parameter int NUM_CH   = 2
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  // register port
  input  wire logic [sdfc_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [sdfc_pkg::DATA_W-1:0]   regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [sdfc_pkg::DATA_W-1:0]   regRdata,
  // converter enables and power mode
  input  wire logic [NUM_CH-1:0]             chEnable,
  input  wire logic                          lowPower,
  // filter configuration to the datapath
  output logic                               convReset,
  output logic      [NUM_CH-1:0]             chopEn,
  output logic                               runAvgEn,
  output logic      [5:0]                    averagingFactor,
  output logic                               secondNotch,
  output logic      [6:0]                    decimationFactor,
  output logic      [sdfc_pkg::PERIOD_W-1:0] periodTicks,
  // result timing
  output logic      [NUM_CH-1:0]             resultStrobe,
  output logic      [NUM_CH-1:0]             dataReady,
  output logic                               comboIllegal
);
  import sdfc_pkg::*;

  typedef struct packed {
    logic [15:0]         ctrl;
    sdfc_state_t         state;
    logic [WAKE_W-1:0]   wakeCnt;
    logic [PERIOD_W-1:0] periodCnt;
    logic [2:0]          settleCnt;
    logic                ready;
    logic                convReset;
    logic [NUM_CH-1:0]   chopEn;
    logic                runAvgEn;
    logic [5:0]          avgFactor;
    logic                notch;
    logic [6:0]          decim;
    logic [PERIOD_W-1:0] period;
    logic [2:0]          settle;
    logic [NUM_CH-1:0]   strobe;
    logic [NUM_CH-1:0]   chReady;
    logic                illegal;
    logic [15:0]         rdata;
  } sdfc_regs_t;

  sdfc_regs_t q_r;
  sdfc_regs_t q_nxt;
  logic       modTick;

  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CNT - 1);

  // modulator clock, slowed in low power
  sdfc_rate_gen #(
    .ACC_W  (PHASE_W),
    .INC_HI (INC_NORM),
    .INC_LO (INC_LP)
  ) u_rate (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .lowPower (lowPower),
    .modTick  (modTick)
  );

  // output period in modulator ticks
  function automatic logic [PERIOD_W-1:0] calcPeriod(input logic [15:0] c,
                                                      input logic       lp);
    logic [6:0]          sf;
    logic [5:0]          af;
    logic [PERIOD_W-1:0] base;
    logic [PERIOD_W-1:0] p;
    logic [PERIOD_W-1:0] lim;
    sf = c[SF_MSB:SF_LSB];
    af = c[AF_MSB:AF_LSB];
    if (sf == SF_FORCE_60) begin
      base = PERIOD_60;
    end else if (sf == SF_FORCE_50) begin
      base = PERIOD_50;
    end else begin
      base = PERIOD_W'((PERIOD_W'(sf) + 1'b1) * PERIOD_W'(SINC_OSR));
    end
    if (c[CHOP_BIT]) begin
      p = PERIOD_W'(base * PERIOD_W'(7'(af) + AF_OFFSET)) + PERIOD_W'(CHOP_EXTRA);
    end else if (af != 6'h00) begin
      p = PERIOD_W'(base * PERIOD_W'(7'(af) + AF_OFFSET));
    end else begin
      p = base;
    end
    lim = lp ? MAX_PERIOD_LP : MAX_PERIOD_NORM;
    if (p > lim) begin
      p = lim;
    end
    return p;
  endfunction

  // settling, in output periods
  function automatic logic [2:0] calcSettle(input logic [15:0] c);
    logic [2:0] s;
    if (c[CHOP_BIT]) begin
      s = SETTLE_CHOP;
    end else if (c[AF_MSB:AF_LSB] != 6'h00) begin
      s = SETTLE_AVG + 3'(c[RAVG_BIT]);
    end else begin
      s = SETTLE_PLAIN + 3'(c[RAVG_BIT]);
    end
    return s;
  endfunction

  // pairing check of decimation against averaging
  function automatic logic calcIllegal(input logic [15:0] c);
    logic [6:0] sf;
    logic [5:0] af;
    sf = c[SF_MSB:SF_LSB];
    af = c[AF_MSB:AF_LSB];
    if (sf <= SF_LIMIT_ANY) begin
      return 1'b0;
    end else if (sf <= SF_LIMIT_MID) begin
      return af > AF_LIMIT_MID;
    end else begin
      return af != 6'h00;
    end
  endfunction

  always_comb begin
    logic anyActive;
    logic periodEnd;
    anyActive = |chEnable;
    periodEnd = 1'b0;
    q_nxt = q_r;
    q_nxt.convReset = 1'b0;
    q_nxt.strobe = '0;

    // configuration derived from the control word
    for (int i = 0; i < NUM_CH; i++) begin
      q_nxt.chopEn[i] = q_r.ctrl[CHOP_BIT] & chEnable[i];
    end
    q_nxt.runAvgEn = q_r.ctrl[RAVG_BIT] | q_r.ctrl[CHOP_BIT];
    q_nxt.avgFactor = q_r.ctrl[AF_MSB:AF_LSB];
    q_nxt.notch = q_r.ctrl[SECOND_NOTCH_BIT];
    q_nxt.decim = q_r.ctrl[SF_MSB:SF_LSB];
    q_nxt.period = calcPeriod(q_r.ctrl, lowPower);
    q_nxt.settle = calcSettle(q_r.ctrl);
    q_nxt.illegal = calcIllegal(q_r.ctrl);

    // output period counting on modulator ticks
    if (modTick) begin
      if (q_r.periodCnt >= q_r.period - 1'b1) begin
        periodEnd = 1'b1;
      end
    end

    case (q_r.state)
      ST_IDLE: begin
        q_nxt.ready = 1'b0;
        if (anyActive) begin
          q_nxt.state = ST_WAKE;
          q_nxt.wakeCnt = '0;
        end
      end
      ST_WAKE: begin
        if (q_r.wakeCnt >= WAKE_LAST) begin
          q_nxt.state = ST_SETTLE;
          q_nxt.periodCnt = '0;
          q_nxt.settleCnt = '0;
        end else begin
          q_nxt.wakeCnt = q_r.wakeCnt + 1'b1;
        end
      end
      ST_SETTLE: begin
        if (modTick) begin
          q_nxt.periodCnt = q_r.periodCnt + 1'b1;
        end
        if (periodEnd) begin
          q_nxt.periodCnt = '0;
          q_nxt.settleCnt = q_r.settleCnt + 1'b1;
          if (q_r.settleCnt >= q_r.settle - 1'b1) begin
            q_nxt.state = ST_RUN;
            q_nxt.ready = 1'b1;
            q_nxt.strobe = chEnable;
          end
        end
      end
      ST_RUN: begin
        if (modTick) begin
          q_nxt.periodCnt = q_r.periodCnt + 1'b1;
        end
        if (periodEnd) begin
          q_nxt.periodCnt = '0;
          q_nxt.strobe = chEnable;
        end
      end
      default: begin
        q_nxt.state = ST_IDLE;
      end
    endcase

    // all converters off: back to idle, drop ready and result strobes
    if (!anyActive) begin
      q_nxt.state = ST_IDLE;
      q_nxt.ready = 1'b0;
      q_nxt.strobe = '0;
    end

    // control write restarts both converters from scratch
    if (regWr && regAddr == FLT_CTRL_ADDR) begin
      q_nxt.ctrl = regWdata;
      q_nxt.convReset = 1'b1;
      q_nxt.state = anyActive ? ST_WAKE : ST_IDLE;
      q_nxt.wakeCnt = '0;
      q_nxt.periodCnt = '0;
      q_nxt.settleCnt = '0;
      q_nxt.ready = 1'b0;
      q_nxt.strobe = '0;
    end

    q_nxt.chReady = q_nxt.ready ? chEnable : '0;

    // read data valid the cycle after the strobe only
    q_nxt.rdata = '0;
    if (regRd) begin
      case (regAddr)
        FLT_CTRL_ADDR: begin
          q_nxt.rdata = q_r.ctrl;
        end
        FLT_STATUS_ADDR: begin
          q_nxt.rdata[STAT_READY_BIT] = q_r.ready;
          q_nxt.rdata[STAT_SETTLE_BIT] = (q_r.state == ST_WAKE) ||
                                         (q_r.state == ST_SETTLE);
          q_nxt.rdata[STAT_ILLEGAL_BIT] = q_r.illegal;
          q_nxt.rdata[STAT_LP_BIT] = lowPower;
          q_nxt.rdata[STAT_STATE_LSB+1:STAT_STATE_LSB] = q_r.state;
        end
        FLT_PERIOD_ADDR: begin
          q_nxt.rdata = (q_r.period > PERIOD_W'(16'hffff)) ? 16'hffff :
                        q_r.period[15:0];
        end
        default: begin
          q_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
      q_r.ctrl <= FLT_CTRL_RESET;
      q_r.state <= ST_IDLE;
      q_r.settle <= SETTLE_PLAIN;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign regRdata         = q_r.rdata;
  assign convReset        = q_r.convReset;
  assign chopEn           = q_r.chopEn;
  assign runAvgEn         = q_r.runAvgEn;
  assign averagingFactor  = q_r.avgFactor;
  assign secondNotch      = q_r.notch;
  assign decimationFactor = q_r.decim;
  assign periodTicks      = q_r.period;
  assign resultStrobe     = q_r.strobe;
  assign dataReady        = q_r.chReady;
  assign comboIllegal     = q_r.illegal;

endmodule

//--- rtl/sdfc_pkg.sv
// shared constants for the sigma-delta decimation filter control block
package sdfc_pkg;

  // register bus
  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 16;
  localparam logic [31:0] FLT_CTRL_ADDR   = 32'hffff0518;
  localparam logic [31:0] FLT_STATUS_ADDR = 32'hffff0524;
  localparam logic [31:0] FLT_PERIOD_ADDR = 32'hffff0528;
  localparam logic [15:0] FLT_CTRL_RESET  = 16'h0007;

  // control register fields
  localparam int CHOP_BIT   = 15;
  localparam int RAVG_BIT   = 14;
  localparam int AF_MSB     = 13;
  localparam int AF_LSB     = 8;
  localparam int SECOND_NOTCH_BIT = 7;
  localparam int SF_MSB     = 6;
  localparam int SF_LSB     = 0;

  // status register fields
  localparam int STAT_READY_BIT   = 0;
  localparam int STAT_SETTLE_BIT  = 1;
  localparam int STAT_ILLEGAL_BIT = 2;
  localparam int STAT_LP_BIT      = 3;
  localparam int STAT_STATE_LSB   = 4;

  // modulator clock rates and sinc3 arithmetic
  localparam longint SYS_HZ         = 250000000;
  localparam longint MOD_HZ_NORM    = 512000;
  localparam longint MOD_HZ_LP      = 131000;
  localparam int     PHASE_W        = 32;
  localparam logic [31:0] INC_NORM  = 32'((MOD_HZ_NORM << PHASE_W) / SYS_HZ);
  localparam logic [31:0] INC_LP    = 32'((MOD_HZ_LP << PHASE_W) / SYS_HZ);
  localparam int     PERIOD_W       = 24;
  localparam logic [6:0]  SF_MAX_FORMULA = 7'h7d;
  localparam logic [6:0]  SF_FORCE_60    = 7'h7e;
  localparam logic [6:0]  SF_FORCE_50    = 7'h7f;
  localparam logic [7:0]  SINC_OSR       = 8'h40;
  localparam logic [6:0]  AF_OFFSET      = 7'h03;
  localparam logic [1:0]  CHOP_EXTRA     = 2'h3;
  localparam longint FORCED_A_HZ    = 60;
  localparam longint FORCED_B_HZ    = 50;
  localparam logic [PERIOD_W-1:0] PERIOD_60 = PERIOD_W'(MOD_HZ_NORM / FORCED_A_HZ);
  localparam logic [PERIOD_W-1:0] PERIOD_50 = PERIOD_W'(MOD_HZ_NORM / FORCED_B_HZ);
  localparam longint MIN_RATE_NORM_HZ = 4;
  localparam longint MIN_RATE_LP_HZ   = 1;
  localparam logic [PERIOD_W-1:0] MAX_PERIOD_NORM = PERIOD_W'(MOD_HZ_NORM / MIN_RATE_NORM_HZ);
  localparam logic [PERIOD_W-1:0] MAX_PERIOD_LP   = PERIOD_W'(MOD_HZ_LP / MIN_RATE_LP_HZ);

  // settling, in output periods
  localparam logic [2:0] SETTLE_PLAIN = 3'h3;
  localparam logic [2:0] SETTLE_AVG   = 3'h1;
  localparam logic [2:0] SETTLE_CHOP  = 3'h2;

  // allowed decimation/averaging pairings
  localparam logic [6:0] SF_LIMIT_ANY = 7'h1f;
  localparam logic [6:0] SF_LIMIT_MID = 7'h3f;
  localparam logic [5:0] AF_LIMIT_MID = 6'h07;

  // startup delay before the first result
  localparam int WAKE_US     = 60;
  localparam int WAKE_CYCLES = int'((longint'(WAKE_US) * SYS_HZ + 999999) / 1000000);
  localparam int WAKE_W      = 16;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAKE   = 2'b01,
    ST_SETTLE = 2'b10,
    ST_RUN    = 2'b11
  } sdfc_state_t;

endpackage

//--- rtl/sdfc_rate_gen.sv
// fractional divider making the modulator-rate tick from the system clock
`timescale 1ns/1ns
module sdfc_rate_gen #(
  parameter int                        ACC_W   = sdfc_pkg::PHASE_W,
  parameter logic [sdfc_pkg::PHASE_W-1:0] INC_HI = sdfc_pkg::INC_NORM,
  parameter logic [sdfc_pkg::PHASE_W-1:0] INC_LO = sdfc_pkg::INC_LP
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // rate select
  input  wire logic lowPower,
  // modulator tick
  output logic      modTick
);
  import sdfc_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0] phase;
    logic             tick;
  } sdfc_rg_t;

  sdfc_rg_t q_r;
  sdfc_rg_t q_nxt;

  always_comb begin
    logic [ACC_W:0] sum;
    sum = '0;
    q_nxt = q_r;
    sum = {1'b0, q_r.phase} + {1'b0, (lowPower ? INC_LO : INC_HI)};
    q_nxt.phase = sum[ACC_W-1:0];
    q_nxt.tick = sum[ACC_W];
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign modTick = q_r.tick;

endmodule

//--- verif/sdfc_filter_ctrl_props.sv
// assertion checker for the decimation filter control block
`timescale 1ns/1ns
module sdfc_filter_ctrl_props
  import sdfc_pkg::*;
#(
  parameter int WAKE_CNT = 8,
  parameter int NUM_CH   = 2
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rstn,
  // register port
  input wire logic [31:0]       regAddr,
  input wire logic [15:0]       regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [15:0]       regRdata,
  // enables and power mode
  input wire logic [NUM_CH-1:0] chEnable,
  input wire logic              lowPower,
  // configuration and timing outputs
  input wire logic              convReset,
  input wire logic [NUM_CH-1:0] chopEn,
  input wire logic              runAvgEn,
  input wire logic [5:0]        averagingFactor,
  input wire logic              secondNotch,
  input wire logic [6:0]        decimationFactor,
  input wire logic [23:0]       periodTicks,
  input wire logic [NUM_CH-1:0] resultStrobe,
  input wire logic [NUM_CH-1:0] dataReady,
  input wire logic              comboIllegal
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic [15:0] sinceRst_r;

  // cycles since the last converter restart
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sinceRst_r <= 16'h0000;
    end else if (convReset) begin
      sinceRst_r <= 16'h0000;
    end else if (sinceRst_r != 16'hffff) begin
      sinceRst_r <= sinceRst_r + 16'h0001;
    end
  end

  function automatic logic [23:0] expPer(logic [15:0] d, logic lp);
    logic [23:0] b;
    logic [23:0] m;
    logic [23:0] p;
    logic [23:0] mx;
    b = (d[6:0] == 7'h7e) ? PERIOD_60 : (d[6:0] == 7'h7f) ? PERIOD_50 :
        {11'h000, d[6:0] + 7'h01, 6'h00};
    m = (d[15] || d[13:8] != 6'h00) ? 24'h000003 + {18'h00000, d[13:8]} : 24'h000001;
    p = b * m + (d[15] ? 24'h000003 : 24'h000000);
    mx = lp ? MAX_PERIOD_LP : MAX_PERIOD_NORM;
    return (p > mx) ? mx : p;
  endfunction

  function automatic logic ill(logic [15:0] d);
    return (d[6:0] > SF_LIMIT_MID && d[13:8] != 6'h00) ||
           (d[6:0] > SF_LIMIT_ANY && d[13:8] > AF_LIMIT_MID);
  endfunction

  sequence s_wr;
    regWr && regAddr == FLT_CTRL_ADDR ##1 !regWr ##1 !regWr;
  endsequence

  property p_restart;
    regWr && regAddr == FLT_CTRL_ADDR |=> convReset;
  endproperty
  property p_restart_cause;
    convReset |-> $past(regWr && regAddr == FLT_CTRL_ADDR);
  endproperty
  property p_drop;
    convReset |-> !(|dataReady) && !(|resultStrobe);
  endproperty
  property p_chop;
    s_wr |=> chopEn == ({NUM_CH{$past(regWdata[15], 3)}} & $past(chEnable));
  endproperty
  property p_ravg;
    s_wr |=> runAvgEn == ($past(regWdata[14], 3) | $past(regWdata[15], 3));
  endproperty
  property p_fields;
    s_wr |=> {averagingFactor, secondNotch, decimationFactor} == $past(regWdata[13:0], 3);
  endproperty
  property p_per_chop;
    s_wr |=> !$past(regWdata[15], 3) ||
             periodTicks == expPer($past(regWdata, 3), $past(lowPower));
  endproperty
  property p_per_plain;
    s_wr |=> $past(regWdata[15], 3) ||
             periodTicks == expPer($past(regWdata, 3), $past(lowPower));
  endproperty
  property p_illegal;
    s_wr |=> comboIllegal == ill($past(regWdata, 3));
  endproperty
  property p_wake;
    |dataReady |-> int'(sinceRst_r) > WAKE_CNT;
  endproperty
  property p_first;
    $rose(dataReady[0]) |-> resultStrobe[0];
  endproperty

  a_restart: assert property (p_restart) else $error("no restart pulse");
  a_restart_cause: assert property (p_restart_cause) else $error("stray restart");
  a_drop: assert property (p_drop) else $error("ready kept over restart");
  a_chop: assert property (p_chop) else $error("chop enables wrong");
  a_ravg: assert property (p_ravg) else $error("running average wrong");
  a_fields: assert property (p_fields) else $error("fields wrong");
  a_per_chop: assert property (p_per_chop) else $error("chop period");
  a_per_plain: assert property (p_per_plain) else $error("period");
  a_illegal: assert property (p_illegal) else $error("pair flag wrong");
  a_wake: assert property (p_wake) else $error("ready before wake delay");
  a_first: assert property (p_first) else $error("ready without result");

  c_chop: cover property (regWr && regAddr == FLT_CTRL_ADDR && regWdata[15]);
  c_illegal: cover property ($rose(comboIllegal));
  c_ready: cover property ($rose(dataReady[0]));
endmodule

bind sdfc_filter_ctrl sdfc_filter_ctrl_props #(.WAKE_CNT(WAKE_CNT), .NUM_CH(NUM_CH)) u_props (
  .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .chEnable(chEnable), .lowPower(lowPower),
  .convReset(convReset), .chopEn(chopEn), .runAvgEn(runAvgEn),
  .averagingFactor(averagingFactor), .secondNotch(secondNotch),
  .decimationFactor(decimationFactor), .periodTicks(periodTicks),
  .resultStrobe(resultStrobe), .dataReady(dataReady), .comboIllegal(comboIllegal));

//--- verif/sdfc_filter_ctrl_test.sv
// self-checking bench for the decimation filter control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %0h got %0h", nm, e, g); fail_count++; end end
module sdfc_filter_ctrl_test;
  import sdfc_pkg::*;
  typedef struct {
    logic [15:0] d;
    logic [1:0]  en;
    logic        lp;
    logic [23:0] per;
    logic        rav;
    logic [1:0]  chp;
    logic        ill;
  } sdfc_row_t;
  sdfc_row_t   rows [13] = '{
    '{16'h0000, 2'h3, 1'h0, 24'h000040, 1'h0, 2'h0, 1'h0},
    '{16'h007d, 2'h3, 1'h0, 24'h001f80, 1'h0, 2'h0, 1'h0},
    '{16'h007e, 2'h3, 1'h0, 24'h002155, 1'h0, 2'h0, 1'h0},
    '{16'h00ff, 2'h3, 1'h0, 24'h002800, 1'h0, 2'h0, 1'h0},
    '{16'h4000, 2'h3, 1'h0, 24'h000040, 1'h1, 2'h0, 1'h0},
    '{16'h0205, 2'h3, 1'h0, 24'h000780, 1'h0, 2'h0, 1'h0},
    '{16'h8003, 2'h1, 1'h0, 24'h000303, 1'h1, 2'h1, 1'h0},
    '{16'h8105, 2'h2, 1'h0, 24'h000603, 1'h1, 2'h2, 1'h0},
    '{16'h3f1f, 2'h3, 1'h0, 24'h01f400, 1'h0, 2'h0, 1'h0},
    '{16'h3f1f, 2'h3, 1'h1, 24'h01ffb8, 1'h0, 2'h0, 1'h0},
    '{16'h0820, 2'h3, 1'h0, 24'h005ac0, 1'h0, 2'h0, 1'h1},
    '{16'h0140, 2'h3, 1'h0, 24'h004100, 1'h0, 2'h0, 1'h1},
    '{16'h073f, 2'h3, 1'h0, 24'h00a000, 1'h0, 2'h0, 1'h0}};
  logic        sys_clk;
  logic        rstn;
  logic [31:0] regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  logic [1:0]  chEnable;
  logic        lowPower;
  logic        convReset;
  logic [1:0]  chopEn;
  logic        runAvgEn;
  logic [5:0]  averagingFactor;
  logic        secondNotch;
  logic [6:0]  decimationFactor;
  logic [23:0] periodTicks;
  logic [1:0]  resultStrobe;
  logic [1:0]  dataReady;
  logic        comboIllegal;
  logic [15:0] q;
  int          fail_count = 0;
  int          compares = 0;
  int          n;

  sdfc_filter_ctrl #(.WAKE_CNT(8), .NUM_CH(2)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .chEnable(chEnable), .lowPower(lowPower),
    .convReset(convReset), .chopEn(chopEn), .runAvgEn(runAvgEn),
    .averagingFactor(averagingFactor), .secondNotch(secondNotch),
    .decimationFactor(decimationFactor), .periodTicks(periodTicks),
    .resultStrobe(resultStrobe), .dataReady(dataReady), .comboIllegal(comboIllegal));

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'h0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1 v = regRdata;
  endtask

  task automatic conclude;
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #440000;
    fail_count++;
    conclude;
  end

  initial begin
    rstn = 1'h0;
    regAddr = 32'h0;
    regWdata = 16'h0;
    regWr = 1'h0;
    regRd = 1'h0;
    chEnable = 2'h3;
    lowPower = 1'h0;
    repeat (4) @(posedge sys_clk);
    `CHK("rstPeriod", 24'h000000, periodTicks)
    rstn <= 1'h1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("dfltPeriod", 24'h000200, periodTicks)
    rd(FLT_CTRL_ADDR, q);
    `CHK("dfltCtrl", 16'h0007, q)
    rd(32'hffff051c, q);
    `CHK("unmapped", 16'h0000, q)
    foreach (rows[i]) begin
      @(posedge sys_clk);
      chEnable <= rows[i].en;
      lowPower <= rows[i].lp;
      wr(FLT_CTRL_ADDR, rows[i].d);
      #1 `CHK("restart", 1'h1, convReset)
      `CHK("readyDrop", 2'h0, dataReady)
      @(posedge sys_clk);
      #1 `CHK("restartEnd", 1'h0, convReset)
      @(posedge sys_clk);
      #1 `CHK("period", rows[i].per, periodTicks)
      `CHK("runAvg", rows[i].rav, runAvgEn)
      `CHK("chop", rows[i].chp, chopEn)
      `CHK("pair", rows[i].ill, comboIllegal)
      `CHK("fields", rows[i].d[13:0], {averagingFactor, secondNotch, decimationFactor})
      rd(FLT_CTRL_ADDR, q);
      `CHK("readback", rows[i].d, q)
      rd(FLT_PERIOD_ADDR, q);
      `CHK("periodReg", (rows[i].per > 24'h00ffff) ? 16'hffff : rows[i].per[15:0], q)
    end
    // settle, restart midway with the same value, then settle fully
    @(posedge sys_clk);
    chEnable <= 2'h1;
    wr(FLT_CTRL_ADDR, 16'h0000);
    repeat (1000) @(posedge sys_clk);
    #1 `CHK("earlyReady", 2'h0, dataReady)
    wr(FLT_CTRL_ADDR, 16'h0000);
    n = 0;
    while (dataReady !== 2'h1 && n < 100000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    `CHK("ready", 2'h1, dataReady)
    `CHK("firstResult", 2'h1, resultStrobe)
    `CHK("settleTime", 1'h1, n > 93000 && n < 95500)
    conclude;
  end
endmodule
